/* verilog/pcmv_pkg.sv */
// constants of the variable-rate pcm serial port
package pcmv_pkg;
   localparam int          WORD_W        = 8;
   localparam int          CLK_MHZ       = 125;
   localparam int          STANDBY_MS    = 30;
   localparam int          STANDBY_CYC   = STANDBY_MS * CLK_MHZ * 1000;
   localparam int          MCLK_STOP_US  = 20;
   localparam int          MCLK_STOP_CYC = MCLK_STOP_US * CLK_MHZ;
   localparam int          MCLK_W        = $clog2(MCLK_STOP_CYC + 1);
   localparam int          AZ_W          = 8;
   localparam logic [7:0]  WORD_RST      = 8'h00;
   localparam logic [2:0]  TX_CNT_RST    = 3'h0;
   localparam logic [3:0]  RX_CNT_RST    = 4'h8;
   localparam logic [3:0]  RX_CNT_LAST   = 4'h7;
   localparam logic [7:0]  AZ_RST        = 8'h00;
   localparam logic [7:0]  AZ_MAX        = 8'h7f;
   localparam logic [7:0]  AZ_MIN        = 8'h80;
endpackage : pcmv_pkg

/* verilog/pcmv_port.sv */
// variable-rate pcm highway port: tx/rx shifters, standby, clock watch, autozero
`timescale 1ns/1ps
module pcmv_port
   import pcmv_pkg::*;
#(
   parameter int STANDBY_CYCLES = STANDBY_CYC
)(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              master_clock,
   input  wire logic              rx_clk_tied_rail,
   input  wire logic              power_down_select,
   input  wire logic              tx_bit_clock,
   input  wire logic              tx_frame_sync,
   input  wire logic              rx_bit_clock,
   input  wire logic              rx_frame_sync,
   input  wire logic              rx_pcm_in,
   input  wire logic [WORD_W-1:0] enc_word,
   input  wire logic              enc_valid,
   output logic                   tx_pcm_out,
   output logic                   tx_pcm_oe,
   output logic                   timeslot_strobe_out,
   output logic                   timeslot_strobe_oe,
   output logic [WORD_W-1:0]      rx_word,
   output logic                   rx_word_valid,
   output logic                   tx_standby,
   output logic                   rx_standby,
   output logic [AZ_W-1:0]        az_trim
);
   localparam int SB_W = $clog2(STANDBY_CYCLES + 1);
   localparam logic [SB_W-1:0] SB_LAST = SB_W'(STANDBY_CYCLES - 1);
   localparam logic [MCLK_W-1:0] MCLK_LAST = MCLK_W'(MCLK_STOP_CYC - 1);

   if (STANDBY_CYCLES < 2 || WORD_W != 8 || AZ_W != 8)
   begin : g_bad_param
      $error("pcmv_port: unsupported parameter values");
   end

   // saturating idle counter step, used by the separate idle counter of each channel
   function automatic logic [SB_W-1:0] idle_step(input logic fs, input logic [SB_W-1:0] c);
      if (fs)
         return '0;
      else if (c == SB_LAST)
         return c;
      else
         return c + SB_W'(1);
   endfunction : idle_step

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: [0] -> [1] is the pair, [2] is history for edge finding
   logic [2:0] txc_q, rxc_q, fsx_q, fsr_q, mck_q;
   logic [1:0] dr_q, pdn_q, tie_q;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         txc_q <= '0;
         rxc_q <= '0;
         fsx_q <= '0;
         fsr_q <= '0;
         mck_q <= '0;
         dr_q  <= '0;
         pdn_q <= '0;
         tie_q <= 2'h3;
      end
      else
      begin
         txc_q <= {txc_q[1:0], tx_bit_clock};
         rxc_q <= {rxc_q[1:0], rx_bit_clock};
         fsx_q <= {fsx_q[1:0], tx_frame_sync};
         fsr_q <= {fsr_q[1:0], rx_frame_sync};
         mck_q <= {mck_q[1:0], master_clock};
         dr_q  <= {dr_q[0], rx_pcm_in};
         pdn_q <= {pdn_q[0], power_down_select};
         tie_q <= {tie_q[0], rx_clk_tied_rail};
      end
   end

   logic txc_rise, rxc_fall, fsx_rise, fsr_rise, mck_edge, en_w;
   assign txc_rise = txc_q[1] & ~txc_q[2];
   assign rxc_fall = ~rxc_q[1] & rxc_q[2];
   assign fsx_rise = fsx_q[1] & ~fsx_q[2];
   assign fsr_rise = fsr_q[1] & ~fsr_q[2];
   assign mck_edge = mck_q[1] ^ mck_q[2];

   ////////////////////////////////////////////////////////////////////////////////
   // port state
   logic [WORD_W-1:0] tx_word_q, tx_word_d, tx_pend_q, tx_pend_d;
   logic [2:0]        tx_cnt_q, tx_cnt_d;
   logic [SB_W-1:0]   tx_idle_q, tx_idle_d, rx_idle_q, rx_idle_d;
   logic              tx_sb_q, tx_sb_d, rx_sb_q, rx_sb_d;
   logic [WORD_W-1:0] rx_shift_q, rx_shift_d, rx_word_q, rx_word_d;
   logic [3:0]        rx_cnt_q, rx_cnt_d;
   logic              rx_valid_q, rx_valid_d;
   logic [MCLK_W-1:0] mck_cnt_q, mck_cnt_d;
   logic              mck_stop_q, mck_stop_d;
   logic [AZ_W-1:0]   az_q, az_d;
   logic              out_q, out_d, oe_q, oe_d;
   logic [WORD_W-1:0] word_src;
   logic [2:0]        cnt_src;
   logic [3:0]        rcnt_src;
   logic              tx_bit_now;

   // fixed-rate mode is not served, so tying the rx clock to the rail idles the port
   assign en_w = ~tie_q[1] & pdn_q[1] & ~mck_stop_q;

   always_comb
   begin
      tx_pend_d  = enc_valid ? enc_word : tx_pend_q;
      word_src   = fsx_rise ? tx_pend_q : tx_word_q;
      cnt_src    = fsx_rise ? TX_CNT_RST : tx_cnt_q;
      tx_bit_now = word_src[3'h7 - cnt_src];
      tx_word_d  = word_src;
      tx_cnt_d   = cnt_src;
      out_d      = out_q;
      oe_d       = oe_q;
      tx_idle_d  = idle_step(fsx_q[1], tx_idle_q);
      tx_sb_d    = fsx_q[1] ? 1'b0 : (tx_sb_q | (tx_idle_q == SB_LAST));
      if (en_w && fsx_q[1] && txc_rise && !tx_sb_q)
      begin
         out_d    = tx_bit_now;
         oe_d     = 1'b1;
         tx_cnt_d = cnt_src + 3'h1;
      end
      if (!en_w || !fsx_q[1] || tx_sb_q)
      begin
         out_d = 1'b0;
         oe_d  = 1'b0;
      end

      // after eight bits the receiver waits for the next sync rising edge
      rcnt_src   = fsr_rise ? 4'h0 : rx_cnt_q;
      rx_cnt_d   = rcnt_src;
      rx_shift_d = rx_shift_q;
      rx_word_d  = rx_word_q;
      rx_valid_d = 1'b0;
      rx_idle_d  = idle_step(fsr_q[1], rx_idle_q);
      rx_sb_d    = fsr_q[1] ? 1'b0 : (rx_sb_q | (rx_idle_q == SB_LAST));
      if (en_w && fsr_q[1] && rxc_fall && !rx_sb_q && rcnt_src < RX_CNT_RST)
      begin
         rx_shift_d = {rx_shift_q[WORD_W-2:0], dr_q[1]};
         rx_cnt_d   = rcnt_src + 4'h1;
         if (rcnt_src == RX_CNT_LAST)
         begin
            rx_word_d  = {rx_shift_q[WORD_W-2:0], dr_q[1]};
            rx_valid_d = 1'b1;
         end
      end

      mck_cnt_d  = mck_edge ? '0 : ((mck_cnt_q == MCLK_LAST) ? mck_cnt_q
                                                            : mck_cnt_q + MCLK_W'(1));
      mck_stop_d = mck_edge ? 1'b0 : (mck_stop_q | (mck_cnt_q == MCLK_LAST));

      // sign bit set means positive: trim tracks the sign-bit imbalance, saturating
      az_d = az_q;
      if (enc_valid && en_w)
      begin
         if (enc_word[WORD_W-1] && az_q != AZ_MAX)
            az_d = az_q + 8'h01;
         else if (!enc_word[WORD_W-1] && az_q != AZ_MIN)
            az_d = az_q - 8'h01;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tx_word_q  <= WORD_RST;
         tx_pend_q  <= WORD_RST;
         tx_cnt_q   <= TX_CNT_RST;
         tx_idle_q  <= '0;
         tx_sb_q    <= 1'b1;
         rx_idle_q  <= '0;
         rx_sb_q    <= 1'b1;
         rx_shift_q <= WORD_RST;
         rx_word_q  <= WORD_RST;
         rx_cnt_q   <= RX_CNT_RST;
         rx_valid_q <= 1'b0;
         mck_cnt_q  <= '0;
         mck_stop_q <= 1'b0;
         az_q       <= AZ_RST;
         out_q      <= 1'b0;
         oe_q       <= 1'b0;
      end
      else
      begin
         tx_word_q  <= tx_word_d;
         tx_pend_q  <= tx_pend_d;
         tx_cnt_q   <= tx_cnt_d;
         tx_idle_q  <= tx_idle_d;
         tx_sb_q    <= tx_sb_d;
         rx_idle_q  <= rx_idle_d;
         rx_sb_q    <= rx_sb_d;
         rx_shift_q <= rx_shift_d;
         rx_word_q  <= rx_word_d;
         rx_cnt_q   <= rx_cnt_d;
         rx_valid_q <= rx_valid_d;
         mck_cnt_q  <= mck_cnt_d;
         mck_stop_q <= mck_stop_d;
         az_q       <= az_d;
         out_q      <= out_d;
         oe_q       <= oe_d;
      end
   end

   // strobe is open drain: pulled low exactly while the word is on the highway
   assign tx_pcm_out          = out_q;
   assign tx_pcm_oe           = oe_q;
   assign timeslot_strobe_out = 1'b0;
   assign timeslot_strobe_oe  = oe_q;
   assign rx_word             = rx_word_q;
   assign rx_word_valid       = rx_valid_q;
   assign tx_standby          = tx_sb_q;
   assign rx_standby          = rx_sb_q;
   assign az_trim             = az_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_tx_edge;
      en_w && fsx_q[1] && txc_rise && !tx_sb_q;
   endsequence
   sequence s_rx_last;
      en_w && fsr_q[1] && rxc_fall && !rx_sb_q && !fsr_rise && rx_cnt_q == 4'h7;
   endsequence

   tx_bit_drive_a: assert property (s_tx_edge |=> tx_pcm_oe && tx_pcm_out == $past(tx_bit_now))
      else $error("tx bit not driven on rising tx clock");
   tx_repeat_a: assert property (s_tx_edge ##0 (!fsx_rise && tx_cnt_q == 3'h7) |=> tx_cnt_q == 3'h0)
      else $error("tx word does not repeat");
   tx_float_a: assert property (!fsx_q[1] |=> !tx_pcm_oe && !timeslot_strobe_oe)
      else $error("tx output driven outside timeslot");
   fixed_idle_a: assert property (tie_q[1] |=> !tx_pcm_oe && !rx_word_valid)
      else $error("port active with rx clock tied to rail");
   // one cycle only: power may return at the next edge and a slot may resume
   power_down_a: assert property (!pdn_q[1]
      |=> !tx_pcm_oe && !timeslot_strobe_oe && !rx_word_valid)
      else $error("outputs driven while powered down");
   tx_next_frame_a: assert property (fsx_rise |=> tx_word_q == $past(tx_pend_q))
      else $error("tx word not taken from previous frame sample");
   restart_a: assert property (fsx_rise && !txc_rise |=> tx_cnt_q == 3'h0)
      else $error("tx bit counter not restarted at sync");
   rx_word_a: assert property (s_rx_last |=> rx_word_valid && rx_cnt_q == 4'h8)
      else $error("rx word not delivered after eighth bit");
   standby_a: assert property (tx_sb_q |=> !tx_pcm_oe)
      else $error("tx output driven in standby");
   clock_stop_a: assert property (mck_stop_q |=> !tx_pcm_oe && !timeslot_strobe_oe)
      else $error("outputs driven after master clock stop");
   autozero_a: assert property (enc_valid && en_w && enc_word[7] && az_q != AZ_MAX
                                |=> az_q == $past(az_q) + 8'h01)
      else $error("autozero does not follow sign bit");
endmodule : pcmv_port

/* test/pcmv_hwy.sv */
// highway controller model: bit clocks, frame syncs, rx data, master clock
`timescale 1ns/1ps
module pcmv_hwy (
   output logic      master_clock,
   output logic      tx_bit_clock,
   output logic      tx_frame_sync,
   output logic      rx_bit_clock,
   output logic      rx_frame_sync,
   output logic      rx_pcm_in,
   input  wire logic tx_line
);
   logic        mclk_run = 1'b1;
   logic [15:0] tx_cap   = 16'h0000;
   initial
   begin
      {master_clock, tx_bit_clock, tx_frame_sync} = 3'h0;
      {rx_bit_clock, rx_frame_sync, rx_pcm_in} = 3'h0;
   end
   // fixed master clock whatever the bit rate; stoppable for the clock watch
   always #244 if (mclk_run) master_clock = ~master_clock;
   ////////////////////////////////////////////////////////////////////////////
   // bit clocks only run inside a slot, sync held high for the whole slot
   task automatic tx_slot(input int n);
      tx_frame_sync = 1'b1;
      #80;
      repeat (n)
      begin
         #80 tx_bit_clock = 1'b1;
         #80 tx_bit_clock = 1'b0;
         tx_cap = {tx_cap[14:0], tx_line};
      end
      #80 tx_frame_sync = 1'b0;
   endtask : tx_slot
   task automatic rx_slot(input logic [7:0] w, input int n);
      rx_frame_sync = 1'b1;
      #80;
      for (int i = 0; i < n; i++)
      begin
         // data moves well clear of the falling edge that takes it
         #40 rx_pcm_in = w[7 - (i % 8)];
         #40 rx_bit_clock = 1'b1;
         #80 rx_bit_clock = 1'b0;
      end
      #80 rx_frame_sync = 1'b0;
      rx_pcm_in = ~rx_pcm_in;
   endtask : rx_slot
endmodule : pcmv_hwy

/* test/tb.sv */
// self-checking bench of the variable-rate pcm port
`timescale 1ns/1ps
module tb;
   import pcmv_pkg::*;
   localparam int     SB_CYC = 200;
   logic              clock, rst_n, rail, pwr, enc_valid;
   logic [WORD_W-1:0] enc_word, rx_word;
   logic [AZ_W-1:0]   az_trim;
   logic              tx_out, tx_oe, ts_out, ts_oe, rx_valid, tx_sb, rx_sb;
   wire               mclk, txc, txs, rxc, rxs, rxd, tx_line;
   int                err_count = 0, n_tests = 0, cyc = 0;
   int                oe_cyc = 0, val_cnt = 0, strobe_bad = 0;
   assign tx_line = tx_oe ? tx_out : 1'bz;
   pcmv_port #(.STANDBY_CYCLES(SB_CYC)) i_dut (.clock(clock), .rst_n(rst_n),
      .master_clock(mclk), .rx_clk_tied_rail(rail), .power_down_select(pwr),
      .tx_bit_clock(txc), .tx_frame_sync(txs), .rx_bit_clock(rxc), .rx_frame_sync(rxs),
      .rx_pcm_in(rxd), .enc_word(enc_word), .enc_valid(enc_valid), .tx_pcm_out(tx_out),
      .tx_pcm_oe(tx_oe), .timeslot_strobe_out(ts_out), .timeslot_strobe_oe(ts_oe),
      .rx_word(rx_word), .rx_word_valid(rx_valid), .tx_standby(tx_sb),
      .rx_standby(rx_sb), .az_trim(az_trim));
   pcmv_hwy i_hwy (.master_clock(mclk), .tx_bit_clock(txc), .tx_frame_sync(txs),
      .rx_bit_clock(rxc), .rx_frame_sync(rxs), .rx_pcm_in(rxd), .tx_line(tx_line));
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (tx_oe === 1'b1) oe_cyc++;
      if (rx_valid === 1'b1) val_cnt++;
      if (ts_oe !== tx_oe || ts_out !== 1'b0) strobe_bad++;
      if (cyc == 40000)
      begin
         err_count++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : settle
   task automatic enc_pulse(input logic [7:0] w);
      @(posedge clock);
      #1 enc_word = w;
      enc_valid = 1'b1;
      @(posedge clock);
      #1 enc_valid = 1'b0;
   endtask : enc_pulse
   task automatic test_reset();
      check("reset standby", 16'h0001, 16'(tx_sb & rx_sb));
      check("reset oe and trim", 16'h0000, 16'({tx_oe, az_trim}));
      $display("test reset done");
   endtask : test_reset
   task automatic test_tx();
      enc_pulse(8'ha5);
      settle(2);
      check("az_trim up", 16'h0001, 16'(az_trim));
      strobe_bad = 0;
      i_hwy.tx_slot(16);
      check("tx repeated word", 16'ha5a5, i_hwy.tx_cap);
      settle(6);
      check("tx oe after slot", 16'h0000, 16'(tx_oe));
      check("strobe with data", 16'h0000, 16'(strobe_bad));
      enc_pulse(8'h12);
      i_hwy.tx_slot(8);
      check("tx next word", 16'ha512, i_hwy.tx_cap);
      check("az_trim down", 16'h0000, 16'(az_trim));
      $display("test tx done");
   endtask : test_tx
   task automatic test_rx();
      val_cnt = 0;
      i_hwy.rx_slot(8'h3c, 10);
      settle(4);
      check("rx word", 16'h003c, 16'(rx_word));
      check("rx valid count", 16'h0001, 16'(val_cnt));
      i_hwy.rx_slot(8'hc3, 8);
      settle(4);
      check("rx second word", 16'h00c3, 16'(rx_word));
      check("rx valid count 2", 16'h0002, 16'(val_cnt));
      $display("test rx done");
   endtask : test_rx
   task automatic test_refuse();
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clock);
         #1 pwr = (k != 0);
         rail = (k == 1);
         i_hwy.mclk_run = (k != 2);
         settle(2600);
         oe_cyc = 0;
         val_cnt = 0;
         i_hwy.tx_slot(8);
         i_hwy.rx_slot(8'h55, 8);
         check("idle tx oe", 16'h0000, 16'(oe_cyc));
         check("idle rx valid", 16'h0000, 16'(val_cnt));
      end
      @(posedge clock);
      #1 pwr = 1'b1;
      i_hwy.mclk_run = 1'b1;
      // the master clock must be seen toggling again before the slot starts
      settle(100);
      enc_pulse(8'h6e);
      i_hwy.tx_slot(8);
      check("tx after wake", 16'h006e, 16'(i_hwy.tx_cap[7:0]));
      $display("test refuse done");
   endtask : test_refuse
   task automatic test_standby();
      for (int ch = 0; ch < 2; ch++)
      begin
         if (ch == 0) i_hwy.tx_slot(8);
         else i_hwy.rx_slot(8'h81, 8);
         settle(SB_CYC - 20);
         check("awake before count", 16'h0000, 16'(ch == 0 ? tx_sb : rx_sb));
         settle(40);
         check("standby after count", 16'h0001, 16'(ch == 0 ? tx_sb : rx_sb));
      end
      check("tx oe in standby", 16'h0000, 16'(tx_oe));
      $display("test standby done");
   endtask : test_standby
   task automatic stop_test();
      $display("counts: %0d mismatches in %0d comparisons", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   initial
   begin
      rst_n = 1'b0;
      rail = 1'b0;
      pwr = 1'b1;
      enc_valid = 1'b0;
      enc_word = 8'h00;
      repeat (3) @(posedge clock);
      #1 rst_n = 1'b1;
      settle(6);
      test_reset();
      test_tx();
      test_rx();
      test_refuse();
      test_standby();
      stop_test();
   end
endmodule : tb
